/* design/dac_load_pkg.sv */
/*
  Shared constants for the serial load interface of a 10-bit voltage DAC.
  Assumes every user imports the whole package and runs on one 200 MHz clock.
*/
package dac_load_pkg;

  // Frame layout.
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned CODE_BITS    = 10;
  localparam int unsigned SUB_LSB_BITS = 2;
  localparam int unsigned CODE_LSB_POS = SUB_LSB_BITS;
  localparam int unsigned CHAIN_POS    = FRAME_BITS - 1;

  // Pin synchroniser depth and pin indices inside the synchronised bundle.
  localparam int unsigned SYNC_STAGES  = 3;
  localparam int unsigned PIN_COUNT    = 3;
  localparam int unsigned PIN_SELECT   = 0;
  localparam int unsigned PIN_SCLK     = 1;
  localparam int unsigned PIN_DATA     = 2;

  // Code buffer between the frame logic and the converter latch.
  localparam int unsigned BUF_DEPTH    = 2;

  // Values after reset, and the ceiling at which the bit count saturates.
  localparam logic [CODE_BITS-1:0]  DAC_RESET      = 10'h000;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET    = 16'h0000;
  localparam logic                  CHAIN_RESET    = 1'h0;
  localparam logic [PIN_COUNT-1:0]  PIN_RESET      = 3'h5;
  localparam logic [4:0]            COUNT_RESET    = 5'h00;
  localparam logic [4:0]            COUNT_MAX      = 5'h1F;

  // Full scale of the straight binary transfer: out = 2 * reference_input * code / 1024.
  localparam int unsigned CODE_FULL_SCALE = 1024;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } frame_state_e;

endpackage

/* design/pin_sync.sv */
/*
  Three-stage synchroniser with an agreement filter for a bundle of pins.
  Assumes the pins are asynchronous to clk; the output follows a pin only once
  the second and third stages agree.
*/
`timescale 1ns/1ps
module pin_sync
  import dac_load_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [PIN_COUNT-1:0] pinIn,
  output logic      [PIN_COUNT-1:0] pinOut
);

  typedef struct packed
  {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    logic [PIN_COUNT-1:0] filt;
  } sync_s;

  sync_s q;
  sync_s d;

  // The first stage feeds only the second; filtering looks at stages two and three.
  always_comb
  begin
    d      = q;
    d.s1   = pinIn;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.filt = (q.s3 & ~(q.s2 ^ q.s3)) | (q.filt & (q.s2 ^ q.s3));
    if (!nrst)
    begin
      d.s1   = PIN_RESET;
      d.s2   = PIN_RESET;
      d.s3   = PIN_RESET;
      d.filt = PIN_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    q <= d;
  end

  assign pinOut = q.filt;

endmodule

/* design/code_buffer.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes a single clock; full and empty are exact, a push while full is refused.
*/
`timescale 1ns/1ps
module code_buffer
  import dac_load_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 inValid,
  output logic                      inReady,
  input  wire logic [CODE_BITS-1:0] inData,
  output logic                      outValid,
  input  wire logic                 outReady,
  output logic      [CODE_BITS-1:0] outData
);

  typedef struct packed
  {
    logic [BUF_DEPTH-1:0][CODE_BITS-1:0] mem;
    logic                                wrPtr;
    logic                                rdPtr;
    logic [1:0]                          count;
  } buf_s;

  buf_s q;
  buf_s d;
  logic push;
  logic pop;

  always_comb
  begin
    d        = q;
    inReady  = (q.count != 2'(BUF_DEPTH));
    outValid = (q.count != 2'h0);
    push     = inValid & inReady;
    pop      = outValid & outReady;
    if (push)
    begin
      d.mem[q.wrPtr] = inData;
      d.wrPtr        = ~q.wrPtr;
    end
    if (pop)
    begin
      d.rdPtr = ~q.rdPtr;
    end
    if (push && !pop)
    begin
      d.count = q.count + 2'h1;
    end
    else if (pop && !push)
    begin
      d.count = q.count - 2'h1;
    end
    if (!nrst)
    begin
      d.mem   = '0;
      d.wrPtr = 1'h0;
      d.rdPtr = 1'h0;
      d.count = 2'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    q <= d;
  end

  assign outData = q.mem[q.rdPtr];

endmodule

/* design/dac_serial_load.sv */
/*
  Serial load interface of a 10-bit voltage-output DAC: shift register, chain
  output and DAC register, paced by the host's chip select and shift clock.
  Assumes the host pins are asynchronous to clk and each shift clock phase lasts
  well over five clk periods; the analog converter takes codes through convReady.
*/
`timescale 1ns/1ps
module dac_serial_load
  import dac_load_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 selectN,
  input  wire logic                 shiftClk,
  input  wire logic                 serialIn,
  output logic                      chainOut,
  input  wire logic                 convReady,
  output logic      [CODE_BITS-1:0] dacCode,
  output logic                      codeUpdate,
  output logic                      loadReady,
  output logic                      loadDropped,
  output logic      [4:0]           frameBits
);

  typedef struct packed
  {
    frame_state_e          state;
    logic [FRAME_BITS-1:0] shift;
    logic                  chain;
    logic                  sclkLast;
    logic [CODE_BITS-1:0]  dac;
    logic                  update;
    logic                  dropped;
    logic [4:0]            count;
    logic [4:0]            lastCount;
  } load_s;

  load_s                q;
  load_s                d;
  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] pinSync;
  logic                 selHigh;
  logic                 sclkNow;
  logic                 dataNow;
  logic                 sclkRise;
  logic                 sclkFall;
  logic                 pushValid;
  logic                 pushReady;
  logic [CODE_BITS-1:0] pushCode;
  logic                 popValid;
  logic                 popReady;
  logic [CODE_BITS-1:0] popCode;

  assign pinRaw[PIN_SELECT] = selectN;
  assign pinRaw[PIN_SCLK]   = shiftClk;
  assign pinRaw[PIN_DATA]   = serialIn;

  // All three pins share one latency, so data stays aligned with its clock edge.
  pin_sync u_sync
  (
    .clk    (clk),
    .nrst   (nrst),
    .pinIn  (pinRaw),
    .pinOut (pinSync)
  );

  assign selHigh = pinSync[PIN_SELECT];
  assign sclkNow = pinSync[PIN_SCLK];
  assign dataNow = pinSync[PIN_DATA];

  // The buffer lets a frame complete while the converter is still busy with the last code.
  code_buffer u_buf
  (
    .clk      (clk),
    .nrst     (nrst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushCode),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popCode)
  );

  // The converter latch takes a code only when the analog side says it can.
  assign popReady = convReady;

  always_comb
  begin
    d         = q;
    sclkRise  = sclkNow & ~q.sclkLast;
    sclkFall  = ~sclkNow & q.sclkLast;
    pushValid = 1'h0;
    pushCode  = q.shift[CODE_LSB_POS +: CODE_BITS];
    d.sclkLast = sclkNow;
    d.update   = 1'h0;

    unique case (q.state)
      ST_IDLE:
      begin
        // Edges while deselected are ignored; shift register and chain output hold.
        if (!selHigh)
        begin
          d.state = ST_SHIFT;
          d.count = COUNT_RESET;
        end
      end
      ST_SHIFT:
      begin
        if (selHigh)
        begin
          pushValid = 1'h1;
          d.state   = ST_IDLE;
          d.lastCount = q.count;
          // With no room the word is lost; the host must honour loadReady.
          if (!pushReady)
          begin
            d.dropped = 1'h1;
          end
        end
        else
        begin
          if (sclkRise)
          begin
            d.shift = {q.shift[FRAME_BITS-2:0], dataNow};
            if (q.count != COUNT_MAX)
            begin
              d.count = q.count + 5'h01;
            end
          end
          if (sclkFall)
          begin
            d.chain = q.shift[CHAIN_POS];
          end
        end
      end
    endcase

    // Straight binary code is handed to the converter unchanged.
    if (popValid && popReady)
    begin
      d.dac    = popCode;
      d.update = 1'h1;
    end

    if (!nrst)
    begin
      d.state     = ST_IDLE;
      d.shift     = SHIFT_RESET;
      d.chain     = CHAIN_RESET;
      d.sclkLast  = 1'h0;
      d.dac       = DAC_RESET;
      d.update    = 1'h0;
      d.dropped   = 1'h0;
      d.count     = COUNT_RESET;
      d.lastCount = COUNT_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    q <= d;
  end

  // The chain output is a plain driven pin; it never floats.
  assign chainOut    = q.chain;
  assign dacCode     = q.dac;
  assign codeUpdate  = q.update;
  assign loadReady   = pushReady;
  assign loadDropped = q.dropped;
  assign frameBits   = q.lastCount;

endmodule

/* sim/dac_serial_load_asserts.sv */
/*
  Assertions on the ports of dac_serial_load.
  Assumes a single clk domain with synchronous reset nrst.
*/
`timescale 1ns/1ps
module dac_serial_load_asserts
  import dac_load_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 selectN,
  input wire logic                 shiftClk,
  input wire logic                 chainOut,
  input wire logic                 convReady,
  input wire logic [CODE_BITS-1:0] dacCode,
  input wire logic                 codeUpdate,
  input wire logic                 loadReady,
  input wire logic                 loadDropped,
  input wire logic [4:0]           frameBits
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_reset_clear: assert property ($rose(nrst) |-> dacCode == 10'h000 && !codeUpdate)
    else $error("dac code not zero after reset");
  a_load_prompt: assert property ($rose(selectN) && convReady && loadReady |-> ##[3:10] codeUpdate)
    else $error("select rise did not load the code");
  a_update_cause: assert property (codeUpdate |-> $past(convReady))
    else $error("code update without converter ready");
  a_code_change: assert property ($changed(dacCode) |-> codeUpdate)
    else $error("dac code changed without update");
  a_chain_fall: assert property ($changed(chainOut) |-> !shiftClk && !$past(selectN, 5))
    else $error("chain output moved outside a clock fall");
  a_chain_idle: assert property (selectN && $past(selectN, 8) |-> $stable(chainOut))
    else $error("chain output moved while deselected");
  a_count_frame: assert property ($changed(frameBits) |-> selectN)
    else $error("bit count moved inside a frame");
  a_drop_sticky: assert property (loadDropped |=> loadDropped)
    else $error("drop flag cleared without reset");

  cover property (codeUpdate ##1 codeUpdate);
  cover property ($rose(loadDropped));
  cover property ($changed(chainOut));
endmodule

bind dac_serial_load dac_serial_load_asserts u_chk
(
  .clk(clk),
  .nrst(nrst),
  .selectN(selectN),
  .shiftClk(shiftClk),
  .chainOut(chainOut),
  .convReady(convReady),
  .dacCode(dacCode),
  .codeUpdate(codeUpdate),
  .loadReady(loadReady),
  .loadDropped(loadDropped),
  .frameBits(frameBits)
);

/* sim/dac_host.sv */
/*
  Host model driving select, shift clock and data at 80 ns per bit.
  Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
module dac_host
(
  output logic selectN,
  output logic shiftClk,
  output logic serialIn
);
  initial
  begin
    selectN  = 1'h1;
    shiftClk = 1'h0;
    serialIn = 1'h1;
  end

  // Data moves on the fall, so it is stable for a whole half period at the rise.
  task automatic send(input logic [15:0] w, input int n);
    selectN = 1'h0;
    #100;
    for (int i = n - 1; i >= 0; i--)
    begin
      serialIn = w[i];
      #40 shiftClk = 1'h1;
      #40 shiftClk = 1'h0;
    end
    #100 selectN = 1'h1;
    serialIn = ~serialIn;
    #200;
  endtask

  // Pulses while deselected break the parking habit on purpose.
  task automatic pulse();
    repeat (4)
    begin
      #40 shiftClk = 1'h1;
      #40 shiftClk = 1'h0;
    end
  endtask
endmodule

/* sim/tb_top.sv */
/*
  Self-checking bench for dac_serial_load driven by the host model.
  Assumes a 200 MHz clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module tb_top
  import dac_load_pkg::*;
;
  logic                 clk = 1'h0;
  logic                 nrst = 1'h0;
  logic                 convReady = 1'h1;
  logic                 selectN, shiftClk, serialIn, chainOut;
  logic                 codeUpdate, loadReady, loadDropped;
  logic [CODE_BITS-1:0] dacCode;
  logic [4:0]           frameBits;
  logic [CODE_BITS-1:0] got[$];
  int                   n_errors = 0;
  int                   comparisons = 0;

  always #2.5 clk = ~clk;
  // Sampling mid-cycle keeps the capture clear of the edge that launches codeUpdate.
  always @(negedge clk) if (nrst && codeUpdate) got.push_back(dacCode);

  dac_host host (.selectN(selectN), .shiftClk(shiftClk), .serialIn(serialIn));
  dac_serial_load dut (.clk(clk), .nrst(nrst), .selectN(selectN), .shiftClk(shiftClk),
    .serialIn(serialIn), .chainOut(chainOut), .convReady(convReady), .dacCode(dacCode),
    .codeUpdate(codeUpdate), .loadReady(loadReady), .loadDropped(loadDropped),
    .frameBits(frameBits));

  task automatic check_code(input logic [CODE_BITS-1:0] a, input logic [CODE_BITS-1:0] e);
    comparisons++;
    if (a !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, a, e);
    end
  endtask

  task automatic check_bit(input logic a, input logic e);
    comparisons++;
    if (a !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, a, e);
    end
  endtask

  task automatic check_count(input logic [4:0] a, input logic [4:0] e);
    comparisons++;
    if (a !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, a, e);
    end
  endtask

  task automatic t_frames();
    check_code(dacCode, 10'h000);
    host.send({4'h0, 10'h2A5, 2'h0}, 12);
    host.send({4'hA, 10'h3FF, 2'h0}, 16);
    check_bit(chainOut, 1'h1);
    host.send({4'h5, 10'h200, 2'h0}, 16);
    check_bit(chainOut, 1'h0);
    check_count(frameBits, 5'h10);
    check_count(5'(got.size()), 5'h03);
    check_code(got[0], 10'h2A5);
    check_code(got[1], 10'h3FF);
    check_code(got[2], 10'h200);
    $display("test frames done");
  endtask

  task automatic t_idle();
    host.pulse();
    // Give the last stray edge time to pass the synchroniser before judging.
    #100;
    check_bit(chainOut, 1'h0);
    check_count(frameBits, 5'h10);
    check_count(5'(got.size()), 5'h03);
    $display("test idle done");
  endtask

  task automatic t_stall();
    @(posedge clk);
    #1 convReady = 1'h0;
    host.send({4'h0, 10'h011, 2'h0}, 12);
    host.send({4'h0, 10'h022, 2'h0}, 12);
    check_bit(loadReady, 1'h0);
    host.send({4'h0, 10'h033, 2'h0}, 12);
    check_bit(loadDropped, 1'h1);
    check_count(frameBits, 5'h0C);
    @(posedge clk);
    #1 convReady = 1'h1;
    #100;
    check_count(5'(got.size()), 5'h05);
    check_code(got[3], 10'h011);
    check_code(got[4], 10'h022);
    host.send(16'h0000, 16);
    check_code(dacCode, 10'h000);
    $display("test stall done");
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    #1 nrst = 1'h1;
    repeat (4) @(posedge clk);
    // Every host delay is a whole number of clk periods, so this offset keeps pin edges off clk edges.
    #1;
    t_frames();
    t_idle();
    t_stall();
    test_done();
  end

  // Seven frames take about 11 us; the limit leaves ample margin.
  initial
  begin
    #40000;
    n_errors++;
    test_done();
  end
endmodule
